/* sffr_defines.vh */
/*
  constants for the fault flag register bank: offsets, bit positions,
  reset values and masks.
  assumes inclusion by bare name from the design files.
*/
`ifndef SFFR_DEFINES_VH
`define SFFR_DEFINES_VH

`define SFFR_ADDR_W          8
`define SFFR_OFS_UPPER       8'h00
`define SFFR_OFS_LOWER       8'h01
`define SFFR_OFS_LAST_VALID  8'h1f

`define SFFR_UP_LOW_VREG     0
`define SFFR_UP_MEAS_TMO     1

`define SFFR_LO_AFE_FAIL     0
`define SFFR_LO_BAD_ADDR     1
`define SFFR_LO_ALGO_ERR     2
`define SFFR_LO_CAL_FAIL     3
`define SFFR_LO_SELF_DIAG    4
`define SFFR_LO_OUT_RANGE    5
`define SFFR_LO_MEM_ERR      6
`define SFFR_LO_NO_MEAS      7

`define SFFR_UPPER_RESET     8'h00
`define SFFR_LOWER_RESET     8'h80
`define SFFR_UPPER_MASK      8'h03
`define SFFR_BYTE_ZERO       8'h00

`define SFFR_SYNC_RESET      2'h0

`endif

/* sffr_host.sv */
/* register port master; assumes calls after reset */
`timescale 1ns/1ps
module sffr_host (
  input wire clk,
  input wire [7:0] reg_rdata,
  output reg [7:0] reg_addr = 8'h00,
  output reg reg_rd = 1'b0,
  output reg reg_wr = 1'b0,
  output reg [7:0] reg_wdata = 8'h00
);
  task xfer(input w, input [7:0] a, output [7:0] d);
    @(posedge clk) #1 {reg_rd, reg_wr, reg_addr, reg_wdata} = {!w, w, a, ~a};
    @(posedge clk) #1 {reg_rd, reg_wr, reg_addr} = {2'b00, ~a};
    d = reg_rdata;
  endtask
endmodule // sffr_host

/* sffr_regs.v */
/*
  read-only fault flag word of a gas sensor: two bytes reached through
  the register read/write port that the serial target logic drives.
  assumes the serial transport decodes transfers into one-cycle rd/wr
  strobes with an address, on clk; the regulated-voltage monitor is an
  asynchronous analog level, all other events are clk-domain pulses.
  assumes clk_en low freezes every flop, the synchroniser included;
  reg_wdata is taken but never stored, both bytes being read-only;
  addresses above the last valid one, 0x1f, count as not existing;
  the measurement engine drives meas_done and meas_timeout.
*/
`timescale 1ns/1ps
`include "sffr_defines.vh"

// What this block does
// - fault word is two read-only bytes, upper at 0x00, lower at 0x01
// - upper bit 0 set while regulated supply is too low
// - upper bit 1 set when a measurement does not finish in time
// - measurement timeout flag cleared by a later successful measurement
// - lower bit 0 set when analog front end initialisation fails, fatal
// - lower bit 1 set on access to a register address that does not exist
// - lower bit 3 set when any calibration fails
// - lower bit 7 set at start-up, cleared after first completed measurement
// - lower bit 6 set on internal memory operation error
// - lower bit 5 set when concentration lies outside measurement range
module sffr_regs
(
  clk,
  reset_n,
  clk_en,
  reg_addr,
  reg_rd,
  reg_wr,
  reg_wdata,
  reg_rdata,
  reg_rvalid,
  vreg_low,
  meas_timeout,
  meas_done,
  afe_init_fail,
  cal_fail,
  algo_err,
  self_diag_err,
  out_of_range,
  in_range,
  mem_err,
  fault_upper,
  fault_lower
);
  input  wire                    clk;
  input  wire                    reset_n;
  input  wire                    clk_en;
  input  wire [`SFFR_ADDR_W-1:0] reg_addr;
  input  wire                    reg_rd;
  input  wire                    reg_wr;
  input  wire [7:0]              reg_wdata;
  output reg  [7:0]              reg_rdata;
  output reg                     reg_rvalid;
  input  wire                    vreg_low;
  input  wire                    meas_timeout;
  input  wire                    meas_done;
  input  wire                    afe_init_fail;
  input  wire                    cal_fail;
  input  wire                    algo_err;
  input  wire                    self_diag_err;
  input  wire                    out_of_range;
  input  wire                    in_range;
  input  wire                    mem_err;
  output reg  [7:0]              fault_upper;
  output reg  [7:0]              fault_lower;

  wire                           vreg_low_s;
  wire                           bad_access;
  reg  [7:0]                     upper_nxt;
  reg  [7:0]                     lower_nxt;
  reg  [7:0]                     rdata_nxt;

  // ************************
  // address decode
  // ************************
  function addr_exists;
    input [`SFFR_ADDR_W-1:0] a;
    begin
      addr_exists = (a <= `SFFR_OFS_LAST_VALID);
    end
  endfunction

  assign bad_access = (reg_rd | reg_wr) & ~addr_exists(reg_addr);

  // ************************
  // supply monitor input
  // ************************
  sffr_sync u_vreg_sync
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in (vreg_low),
    .sync_out (vreg_low_s)
  );

  // ************************
  // flag update helper
  // ************************
  function flag_step;
    input cur;
    input set_ev;
    input clr_ev;
    begin
      // set wins over a clear in the same cycle
      flag_step = set_ev | (cur & ~clr_ev);
    end
  endfunction

  // ************************
  // upper flag next state
  // ************************
  always @*
  begin
    upper_nxt = `SFFR_BYTE_ZERO;
    upper_nxt[`SFFR_UP_LOW_VREG] = vreg_low_s;
    upper_nxt[`SFFR_UP_MEAS_TMO] = flag_step(fault_upper[`SFFR_UP_MEAS_TMO],
                                             meas_timeout,
                                             meas_done);
    upper_nxt = upper_nxt & `SFFR_UPPER_MASK;
  end

  // ************************
  // lower flag next state
  // ************************
  always @*
  begin
    lower_nxt = `SFFR_BYTE_ZERO;
    lower_nxt[`SFFR_LO_AFE_FAIL] = flag_step(fault_lower[`SFFR_LO_AFE_FAIL],
                                             afe_init_fail,
                                             1'b0);
    lower_nxt[`SFFR_LO_BAD_ADDR] = flag_step(fault_lower[`SFFR_LO_BAD_ADDR],
                                             bad_access,
                                             1'b0);
    lower_nxt[`SFFR_LO_ALGO_ERR] = flag_step(fault_lower[`SFFR_LO_ALGO_ERR],
                                             algo_err,
                                             1'b0);
    lower_nxt[`SFFR_LO_CAL_FAIL] = flag_step(fault_lower[`SFFR_LO_CAL_FAIL],
                                             cal_fail,
                                             1'b0);
    lower_nxt[`SFFR_LO_SELF_DIAG] = flag_step(fault_lower[`SFFR_LO_SELF_DIAG],
                                              self_diag_err,
                                              1'b0);
    lower_nxt[`SFFR_LO_OUT_RANGE] = flag_step(fault_lower[`SFFR_LO_OUT_RANGE],
                                              out_of_range,
                                              in_range);
    lower_nxt[`SFFR_LO_MEM_ERR] = flag_step(fault_lower[`SFFR_LO_MEM_ERR],
                                            mem_err,
                                            1'b0);
    lower_nxt[`SFFR_LO_NO_MEAS] = flag_step(fault_lower[`SFFR_LO_NO_MEAS],
                                            1'b0,
                                            meas_done);
  end

  // ************************
  // read mux
  // ************************
  always @*
  begin
    case (reg_addr)
      `SFFR_OFS_UPPER: rdata_nxt = fault_upper;
      `SFFR_OFS_LOWER: rdata_nxt = fault_lower;
      default:         rdata_nxt = `SFFR_BYTE_ZERO;
    endcase
  end

  // ************************
  // fault byte registers
  // ************************
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      fault_upper <= `SFFR_UPPER_RESET;
    end
    else if (clk_en)
    begin
      // writes are ignored: flags follow events only
      fault_upper <= upper_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      fault_lower <= `SFFR_LOWER_RESET;
    end
    else if (clk_en)
    begin
      fault_lower <= lower_nxt;
    end
  end

  // ************************
  // read port registers
  // ************************
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid <= reg_rd;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_rdata <= `SFFR_BYTE_ZERO;
    end
    else if (clk_en && reg_rd)
    begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule // sffr_regs

/* sffr_regs_assertions.sv */
/* checker on sffr_regs ports; assumes events are clk-domain pulses */
`timescale 1ns/1ps
module sffr_chk (
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire meas_timeout,
  input wire meas_done,
  input wire afe_init_fail,
  input wire cal_fail,
  input wire out_of_range,
  input wire mem_err,
  input wire [7:0] fault_upper,
  input wire [7:0] fault_lower
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rv; clk_en && reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("rv");
  property p_one; reg_rvalid && $past(clk_en) |-> $past(reg_rd); endproperty
  a_one: assert property (p_one) else $error("one");
  property p_res; fault_upper[7:2] == 6'h00; endproperty
  a_res: assert property (p_res) else $error("res");
  property p_tmo; clk_en && meas_timeout |=> fault_upper[1]; endproperty
  a_tmo: assert property (p_tmo) else $error("tmo");
  property p_clr; clk_en && meas_done && !meas_timeout |=> !fault_upper[1]; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_nm; clk_en && meas_done |=> !fault_lower[7]; endproperty
  a_nm: assert property (p_nm) else $error("nm");
  property p_afe; clk_en && afe_init_fail |=> fault_lower[0]; endproperty
  a_afe: assert property (p_afe) else $error("afe");
  property p_bad; clk_en && (reg_rd || reg_wr) && reg_addr > 8'h1f |=> fault_lower[1]; endproperty
  a_bad: assert property (p_bad) else $error("bad");
  property p_cal; clk_en && cal_fail |=> fault_lower[3]; endproperty
  a_cal: assert property (p_cal) else $error("cal");
  property p_mem; clk_en && mem_err |=> fault_lower[6]; endproperty
  a_mem: assert property (p_mem) else $error("mem");
  property p_rng; clk_en && out_of_range |=> fault_lower[5]; endproperty
  a_rng: assert property (p_rng) else $error("rng");
  property p_rdz; clk_en && reg_rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("rdz");
  property p_rdl; clk_en && reg_rd && reg_addr == 8'h01 |=> reg_rdata == $past(fault_lower); endproperty
  a_rdl: assert property (p_rdl) else $error("rdl");
  property p_rst; $rose(reset_n) |-> fault_lower == 8'h80; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_stk; fault_lower[0] |=> fault_lower[0]; endproperty
  a_stk: assert property (p_stk) else $error("stk");
endmodule // sffr_chk
bind sffr_regs sffr_chk u_chk (.*);

/* sffr_regs_tb.sv */
/* bench for sffr_regs; assumes sffr_host as master */
`timescale 1ns/1ps
module sffr_regs_tb;
  reg clk = 1'b0, reset_n = 1'b0, vreg_low = 1'b0, clk_en = 1'b1;
  reg [8:0] e = 9'h000;
  reg [7:0] d;
  integer num_errors = 0, num_checks = 0;
  wire reg_rd, reg_wr, reg_rvalid;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, fault_upper, fault_lower;
  always #5 clk = ~clk;
  sffr_host u_host (.*);
  sffr_regs u_dut (.*, .clk_en(clk_en), .meas_timeout(e[0]), .meas_done(e[1]),
    .afe_init_fail(e[2]), .cal_fail(e[3]), .algo_err(e[4]), .self_diag_err(e[5]),
    .out_of_range(e[6]), .in_range(e[7]), .mem_err(e[8]));
  task chk(input [8:0] seen, input [8:0] exp);
    num_checks = num_checks + 1;
    num_errors = num_errors + (seen !== exp);
    if (seen !== exp) $display("BAD %0t %h %h", $time, seen, exp);
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    u_host.xfer(1'b0, a, d);
    chk({reg_rvalid, d}, {1'b1, exp});
  endtask
  task pulse(input [8:0] m);
    @(posedge clk) #1 e = m;
    @(posedge clk) #1 e = 9'h000;
  endtask
  task t_reset_word;
    rdc(8'h00, 8'h00);
    rdc(8'h01, 8'h80);
  endtask
  task t_meas;
    pulse(9'h001);
    rdc(8'h00, 8'h02);
    @(posedge clk) #1 vreg_low = 1'b1;
    pulse(9'h002);
    rdc(8'h01, 8'h00);
    rdc(8'h00, 8'h01);
  endtask
  task t_sticky;
    pulse(9'h14c);
    u_host.xfer(1'b1, 8'h01, d);
    rdc(8'h01, 8'h69);
    rdc(8'h20, 8'h00);
    rdc(8'h01, 8'h6b);
  endtask
  task t_events;
    pulse(9'h0b0);
    rdc(8'h01, 8'h5f);
    pulse(9'h0c0);
    rdc(8'h01, 8'h7f);
    pulse(9'h003);
    rdc(8'h00, 8'h03);
  endtask
  task t_freeze;
    @(posedge clk) #1 clk_en = 1'b0;
    pulse(9'h002);
    @(posedge clk) #1 clk_en = 1'b1;
    rdc(8'h00, 8'h03);
  endtask
  task t_rerun;
    @(posedge clk) #1 vreg_low = 1'b0;
    repeat (6) @(posedge clk);
    rdc(8'h00, 8'h02);
    @(posedge clk) #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    rdc(8'h01, 8'h80);
    rdc(8'h00, 8'h00);
    u_host.xfer(1'b1, 8'h40, d);
    rdc(8'h01, 8'h82);
  endtask
  task report_and_stop;
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    t_reset_word;
    t_meas;
    t_sticky;
    t_events;
    t_freeze;
    t_rerun;
    report_and_stop;
  end
  initial
  begin
    #5000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // sffr_regs_tb

/* sffr_sync.v */
/*
  three-flop synchroniser with agreement filter for one asynchronous level.
  assumes clk, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
`include "sffr_defines.vh"

module sffr_sync
(
  clk,
  reset_n,
  clk_en,
  async_in,
  sync_out
);
  input  wire clk;
  input  wire reset_n;
  input  wire clk_en;
  input  wire async_in;
  output reg  sync_out;

  reg         meta_r;
  reg  [1:0]  stage_r;

  // ************************
  // synchroniser chain
  // ************************
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_r   <= 1'b0;
      stage_r  <= `SFFR_SYNC_RESET;
      sync_out <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_r   <= async_in;
      stage_r  <= {stage_r[0], meta_r};
      if (stage_r[0] == stage_r[1])
        sync_out <= stage_r[1];
    end
  end
endmodule // sffr_sync
